/* rtl/qed_top.sv */
// Quadrature encoder decoder with position counter, flags and APB registers
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "qed_params.svh"
module qed_top
	import qed_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        phase_a_in,
	input  wire logic        phase_b_in,
	input  wire logic        index_pulse_in,
	output logic             direction_up,
	output logic             velocity_out,
	output logic             irq
);
	logic [`QED_CTRL_W-1:0] ctrl_reg;
	qed_count_t             position_limit;
	qed_count_t             position_count;
	qed_count_t             count_next;
	qed_ratio_t             scale_reg;
	logic [`QED_ST_W-1:0]   flags_reg;
	logic [`QED_ST_W-1:0]   flags_next;
	logic [`QED_ST_W-1:0]   mask_reg;
	logic [`QED_ST_W-1:0]   flag_set;
	logic [`QED_ST_W-1:0]   flag_clr;
	logic [31:0]            prdata_reg;
	logic [31:0]            rd_mux;
	logic                   wr_access;
	logic                   rd_setup;
	logic                   mapped;
	logic                   enable;
	logic                   wr_count;
	logic                   step;
	logic                   idx_clr;
	logic                   pos_event;
	logic                   vel_scaled;
	qed_track_e             track;
	qed_clr_e               clr_mode;

	qed_evt_if evt ();

	// True when the address equals the given word offset
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
		addr_hit = (a == off);
	endfunction

	assign enable   = ctrl_reg[`QED_CTRL_EN];
	assign track    = qed_track_e'(ctrl_reg[`QED_CTRL_HP]);
	assign clr_mode = qed_clr_e'(ctrl_reg[`QED_CTRL_IDX]);

	qed_decoder u_decoder (
		.pclk           (pclk),
		.presetn        (presetn),
		.enable         (enable),
		.x4_mode        (ctrl_reg[`QED_CTRL_X4]),
		.track          (track),
		.phase_a_in     (phase_a_in),
		.phase_b_in     (phase_b_in),
		.index_pulse_in (index_pulse_in),
		.evt            (evt.dec)
	);

	qed_postscale u_postscale (
		.pclk     (pclk),
		.presetn  (presetn),
		.ratio_m1 (scale_reg),
		.vel_in   (evt.vel_pulse),
		.vel_out  (vel_scaled)
	);

	// APB decode; zero wait states, unmapped words answer with an error
	assign wr_access = psel & penable & pwrite;
	assign rd_setup  = psel & ~penable & ~pwrite;
	assign mapped    = addr_hit(paddr, `QED_OFF_CTRL)   | addr_hit(paddr, `QED_OFF_LIMIT) |
	                   addr_hit(paddr, `QED_OFF_COUNT)  | addr_hit(paddr, `QED_OFF_STATUS) |
	                   addr_hit(paddr, `QED_OFF_MASK)   | addr_hit(paddr, `QED_OFF_SCALE) |
	                   addr_hit(paddr, `QED_OFF_STATE);
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~mapped;
	assign wr_count  = wr_access & addr_hit(paddr, `QED_OFF_COUNT);

	// Read mux; reserved bits read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`QED_OFF_CTRL:   rd_mux = {28'h000_0000, ctrl_reg};
			`QED_OFF_LIMIT:  rd_mux = {16'h0000, position_limit};
			`QED_OFF_COUNT:  rd_mux = {16'h0000, position_count};
			`QED_OFF_STATUS: rd_mux = {29'h0000_0000, flags_reg};
			`QED_OFF_MASK:   rd_mux = {29'h0000_0000, mask_reg};
			`QED_OFF_SCALE:  rd_mux = {24'h00_0000, scale_reg};
			`QED_OFF_STATE:  rd_mux = {29'h0000_0000, phase_b_in, phase_a_in, evt.dir_up};
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the setup cycle so it is stable during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_reg <= rd_mux;
		end
	end
	assign prdata = prdata_reg;

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg       <= `QED_RST_CTRL;
			position_limit <= `QED_RST_LIMIT;
			scale_reg      <= `QED_RST_SCALE;
			mask_reg       <= `QED_RST_FLAGS;
		end else if (wr_access) begin
			if (addr_hit(paddr, `QED_OFF_CTRL)) begin
				ctrl_reg <= pwdata[`QED_CTRL_W-1:0];
			end
			if (addr_hit(paddr, `QED_OFF_LIMIT)) begin
				position_limit <= pwdata[15:0];
			end
			if (addr_hit(paddr, `QED_OFF_SCALE)) begin
				scale_reg <= pwdata[7:0];
			end
			if (addr_hit(paddr, `QED_OFF_MASK)) begin
				mask_reg <= pwdata[`QED_ST_W-1:0];
			end
		end
	end

	// Counter control: software load beats index clear, which beats a step
	assign step    = evt.count_pulse;
	assign idx_clr = (clr_mode == QED_CLR_INDEX) & evt.index_event;

	always_comb begin
		count_next = position_count;
		pos_event  = 1'b0;
		if (wr_count) begin
			count_next = pwdata[15:0];
		end else if (idx_clr) begin
			count_next = 16'h0000;
			pos_event  = 1'b1;
		end else if (step) begin
			if (evt.dir_up) begin
				if ((clr_mode == QED_CLR_LIMIT) && (position_count == position_limit)) begin
					count_next = 16'h0000;
					pos_event  = 1'b1;
				end else begin
					count_next = position_count + 16'h0001;
				end
			end else begin
				if ((clr_mode == QED_CLR_LIMIT) && (position_count == 16'h0000)) begin
					// Rolling down under zero reloads the limit
					count_next = position_limit;
					pos_event  = 1'b1;
				end else begin
					count_next = position_count - 16'h0001;
				end
			end
		end
	end

	// Position counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			position_count <= 16'h0000;
		end else begin
			position_count <= count_next;
		end
	end

	// Sticky flags, write one to clear; a new event in the clear cycle wins
	assign flag_set = {evt.dir_change, pos_event, vel_scaled};
	assign flag_clr = (wr_access && addr_hit(paddr, `QED_OFF_STATUS)) ?
	                  pwdata[`QED_ST_W-1:0] : `QED_RST_FLAGS;
	assign flags_next = (flags_reg & ~flag_clr) | flag_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= `QED_RST_FLAGS;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// Interrupt level follows unmasked flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags_next & mask_reg);
		end
	end

	assign direction_up = evt.dir_up;
	assign velocity_out = vel_scaled;

	// Checks on the decoder outputs
	property p_edge_count;
		@(posedge pclk) disable iff (!presetn)
		(enable && $changed(phase_a_in) && $stable(phase_b_in)) |=> evt.count_pulse;
	endproperty
	a_edge_count: assert property (p_edge_count) else $error("A edge gave no count");

	property p_x2_ignores_b;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl_reg[`QED_CTRL_X4] && $changed(phase_b_in) && $stable(phase_a_in))
		|=> !evt.count_pulse;
	endproperty
	a_x2_ignores_b: assert property (p_x2_ignores_b) else $error("x2 counted a B edge");

	property p_dir_decode;
		@(posedge pclk) disable iff (!presetn)
		(enable && $changed(phase_a_in) && $stable(phase_b_in))
		|=> (evt.dir_up == $past(phase_a_in ^ phase_b_in));
	endproperty
	a_dir_decode: assert property (p_dir_decode) else $error("direction misdecoded");

	property p_index_sample;
		@(posedge pclk) disable iff (!presetn)
		(enable && $rose(index_pulse_in)) |=> evt.index_event;
	endproperty
	a_index_sample: assert property (p_index_sample) else $error("index edge lost");

	property p_std_velocity;
		@(posedge pclk) disable iff (!presetn)
		(track == QED_TRACK_STD && $changed(phase_b_in) && $stable(phase_a_in))
		|=> !evt.vel_pulse;
	endproperty
	a_std_velocity: assert property (p_std_velocity) else $error("B edge in standard");

	// Checks on the counter, flags and interrupt
	property p_limit_clear;
		@(posedge pclk) disable iff (!presetn)
		(!wr_count && !idx_clr && step && evt.dir_up && clr_mode == QED_CLR_LIMIT &&
		 position_count == position_limit) |=> (position_count == 16'h0000);
	endproperty
	a_limit_clear: assert property (p_limit_clear) else $error("no clear on limit");

	property p_count_down;
		@(posedge pclk) disable iff (!presetn)
		(!wr_count && !idx_clr && step && !evt.dir_up && position_count != 16'h0000)
		|=> (position_count == $past(position_count) - 16'h0001);
	endproperty
	a_count_down: assert property (p_count_down) else $error("down step wrong");

	property p_pos_flag;
		@(posedge pclk) disable iff (!presetn)
		pos_event |=> flags_reg[`QED_ST_POS] && (irq || !$past(mask_reg[`QED_ST_POS]));
	endproperty
	a_pos_flag: assert property (p_pos_flag) else $error("position flag missed");

	property p_dir_flag;
		@(posedge pclk) disable iff (!presetn)
		evt.dir_change |=> flags_reg[`QED_ST_DIR];
	endproperty
	a_dir_flag: assert property (p_dir_flag) else $error("direction flag missed");

	property p_vel_flag;
		@(posedge pclk) disable iff (!presetn)
		velocity_out |=> flags_reg[`QED_ST_VEL];
	endproperty
	a_vel_flag: assert property (p_vel_flag) else $error("velocity flag missed");

	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		(flags_reg[`QED_ST_POS] && !(wr_access && addr_hit(paddr, `QED_OFF_STATUS)))
		|=> flags_reg[`QED_ST_POS];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped alone");

	property p_irq_masked;
		@(posedge pclk) disable iff (!presetn)
		(mask_reg == 3'h0) [*2] |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt seen");

	// Main scenarios
	c_limit_roll: cover property (@(posedge pclk) disable iff (!presetn)
		pos_event && !idx_clr);
	c_index_clear: cover property (@(posedge pclk) disable iff (!presetn) idx_clr);
	c_reverse: cover property (@(posedge pclk) disable iff (!presetn) evt.dir_change);
	c_scaled: cover property (@(posedge pclk) disable iff (!presetn)
		velocity_out && scale_reg != 8'h00);
endmodule // qed_top

/* pkg/qed_params.svh */
// Register offsets, field positions, reset values and timing counts for the encoder decoder
`ifndef QED_PARAMS_SVH
`define QED_PARAMS_SVH

`define QED_ADDR_W        8
`define QED_OFF_CTRL      8'h00
`define QED_OFF_LIMIT     8'h04
`define QED_OFF_COUNT     8'h08
`define QED_OFF_STATUS    8'h0C
`define QED_OFF_MASK      8'h10
`define QED_OFF_SCALE     8'h14
`define QED_OFF_STATE     8'h18

`define QED_CTRL_EN       0
`define QED_CTRL_X4       1
`define QED_CTRL_IDX      2
`define QED_CTRL_HP       3
`define QED_CTRL_W        4

`define QED_ST_VEL        0
`define QED_ST_POS        1
`define QED_ST_DIR        2
`define QED_ST_W          3

`define QED_RST_CTRL      4'h0
`define QED_RST_LIMIT     16'hFFFF
`define QED_RST_SCALE     8'h00
`define QED_RST_FLAGS     3'h0

`define QED_SYNC_CYCLES   1
`endif

/* pkg/qed_pkg.sv */
// Types shared by the encoder decoder modules
package qed_pkg;
	typedef logic [15:0] qed_count_t;
	typedef logic [7:0]  qed_ratio_t;
	typedef enum logic {
		QED_TRACK_STD = 1'b0,
		QED_TRACK_HP  = 1'b1
	} qed_track_e;
	typedef enum logic {
		QED_CLR_LIMIT = 1'b0,
		QED_CLR_INDEX = 1'b1
	} qed_clr_e;
endpackage

/* pkg/qed_evt_if.sv */
// Decoded encoder events passed from the decoder to the counter logic
`timescale 1ns/1ps
interface qed_evt_if;
	logic count_pulse;
	logic dir_up;
	logic dir_change;
	logic vel_pulse;
	logic index_event;
	modport dec  (output count_pulse, output dir_up, output dir_change,
	              output vel_pulse, output index_event);
	modport sink (input count_pulse, input dir_up, input dir_change,
	              input vel_pulse, input index_event);
endinterface

/* rtl/qed_decoder.sv */
// Phase edge detection, direction decode, index sampling and velocity events
`timescale 1ns/1ps
module qed_decoder
	import qed_pkg::*;
(
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   enable,
	input  wire logic   x4_mode,
	input  qed_track_e  track,
	input  wire logic   phase_a_in,
	input  wire logic   phase_b_in,
	input  wire logic   index_pulse_in,
	qed_evt_if.dec      evt
);
	logic a_prev_reg;
	logic b_prev_reg;
	logic idx_prev_reg;
	logic cp_reg;
	logic dir_reg;
	logic chg_reg;
	logic vel_reg;
	logic idx_reg;
	logic edge_a;
	logic edge_b;
	logic counted;
	logic dir_next;

	// Both phases moving together is a skipped state; it is dropped, not guessed
	assign edge_a   = (phase_a_in ^ a_prev_reg) & ~(phase_b_in ^ b_prev_reg);
	assign edge_b   = (phase_b_in ^ b_prev_reg) & ~(phase_a_in ^ a_prev_reg);
	assign counted  = enable & (edge_a | (x4_mode & edge_b));
	// A edge: A now differs from B means A leads; B edge: B equal to A means A leads
	assign dir_next = edge_a ? (phase_a_in ^ phase_b_in) : ~(phase_a_in ^ phase_b_in);

	// Previous samples of the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_prev_reg   <= 1'b0;
			b_prev_reg   <= 1'b0;
			idx_prev_reg <= 1'b0;
		end else begin
			a_prev_reg   <= phase_a_in;
			b_prev_reg   <= phase_b_in;
			idx_prev_reg <= index_pulse_in;
		end
	end

	// Registered event pulses, one cycle wide
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cp_reg  <= 1'b0;
			chg_reg <= 1'b0;
			vel_reg <= 1'b0;
			idx_reg <= 1'b0;
		end else begin
			cp_reg  <= counted;
			chg_reg <= counted & (dir_next != dir_reg);
			// Standard tracking takes only rising A edges, high precision every count
			vel_reg <= (track == QED_TRACK_HP) ? counted
			           : (enable & edge_a & phase_a_in);
			idx_reg <= enable & index_pulse_in & ~idx_prev_reg;
		end
	end

	// Direction is held between counted edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_reg <= 1'b1;
		end else if (counted) begin
			dir_reg <= dir_next;
		end
	end

	assign evt.count_pulse = cp_reg;
	assign evt.dir_up      = dir_reg;
	assign evt.dir_change  = chg_reg;
	assign evt.vel_pulse   = vel_reg;
	assign evt.index_event = idx_reg;
endmodule // qed_decoder

/* rtl/qed_postscale.sv */
// Velocity postscaler: one output pulse for every ratio_m1 + 1 input pulses
`timescale 1ns/1ps
module qed_postscale
	import qed_pkg::*;
(
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  qed_ratio_t  ratio_m1,
	input  wire logic   vel_in,
	output logic        vel_out
);
	qed_ratio_t cnt_reg;
	logic       out_reg;
	logic       hit;

	// Compare with >= so a smaller ratio written mid-run cannot strand the counter
	assign hit = vel_in & (cnt_reg >= ratio_m1);

	// Input pulse counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
		end else if (hit) begin
			cnt_reg <= 8'h00;
		end else if (vel_in) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// Output is a copy of the winning input pulse, so its width is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg <= 1'b0;
		end else begin
			out_reg <= hit;
		end
	end

	assign vel_out = out_reg;

	property p_scale_hit;
		@(posedge pclk) disable iff (!presetn)
		vel_out |-> $past(vel_in) && ($past(cnt_reg) >= $past(ratio_m1));
	endproperty
	a_scale_hit: assert property (p_scale_hit) else $error("postscaler fired early");
endmodule // qed_postscale

/* testbench/qed_enc_model.sv */
// Behavioural quadrature encoder: two phase lines and an index line
`timescale 1ns/1ps
module qed_enc_model (
	input  wire logic pclk,
	output logic      phase_a,
	output logic      phase_b,
	output logic      index_out
);
	logic [1:0] pos = 2'h0;

	// Gray order 00,10,11,01 going up, so phase A leads phase B
	function automatic logic [1:0] gray(input logic [1:0] p);
		gray = {p[1] ^ p[0], p[1]};
	endfunction

	initial begin
		phase_a = 1'b0;
		phase_b = 1'b0;
		index_out = 1'b0;
	end

	// One quadrature step; only one phase moves, then the lines rest long enough to settle
	task automatic step(input logic up);
		@(posedge pclk);
		pos = up ? pos + 2'h1 : pos - 2'h1;
		{phase_a, phase_b} <= gray(pos);
		repeat (5) @(posedge pclk);
	endtask

	// Index pulse two cycles wide while the phases hold still
	task automatic index_pulse();
		@(posedge pclk);
		index_out <= 1'b1;
		repeat (2) @(posedge pclk);
		index_out <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask
endmodule // qed_enc_model

/* testbench/qed_top_tb_top.sv */
// Self-checking bench for the encoder decoder: APB tasks and encoder scenarios
`timescale 1ns/1ps
`include "qed_params.svh"
module qed_top_tb_top;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pa;
	logic        pb;
	logic        pidx;
	logic        direction_up;
	logic        velocity_out;
	logic        irq;
	logic        vel_prev    = 1'b0;
	int          err_count   = 0;
	int          checks_done = 0;
	int          vel_cnt     = 0;
	logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
	logic [31:0] rv [7] = '{32'h0, 32'h0000FFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

	always #20 pclk = ~pclk;

	qed_top dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phase_a_in(pa), .phase_b_in(pb), .index_pulse_in(pidx),
		.direction_up(direction_up), .velocity_out(velocity_out), .irq(irq)
	);

	qed_enc_model enc (.pclk(pclk), .phase_a(pa), .phase_b(pb), .index_out(pidx));

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen high at a rising edge
	task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
	                        output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 100) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 100) begin
			err_count++;
			$display("Error at %0t: no pready", $time);
			finish_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb_xfer(a, 1'b1, d, q, e);
	endtask

	// Read and compare; pslverr is expected only for addresses above the state register
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb_xfer(a, 1'b0, 32'h0, q, e);
		chk(q, exp, "read data");
		chk({31'h0, e}, {31'h0, a > `QED_OFF_STATE}, "pslverr");
	endtask

	// Velocity output must be single-cycle pulses; count them
	always @(posedge pclk) begin
		if (velocity_out === 1'b1 && vel_prev === 1'b1) begin
			err_count++;
			$display("Error at %0t: velocity pulse too wide", $time);
		end
		if (velocity_out === 1'b1) begin
			vel_cnt++;
		end
		vel_prev <= velocity_out;
	end

	// Hang guard
	initial begin
		repeat (50000) @(posedge pclk);
		err_count++;
		$display("Error at %0t: run timed out", $time);
		finish_test();
	end

	initial begin
		// Bus address and data idle at zero until the first transfer
		paddr  <= 8'h00;
		pwrite <= 1'b0;
		pwdata <= 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rdchk(ra[i], rv[i]);
		end
		wr(8'h1C, 32'hFFFFFFFF);
		rdchk(`QED_OFF_COUNT, 32'h0);
		$display("Test reset values done");
		wr(`QED_OFF_CTRL, 32'h3);
		repeat (4) enc.step(1'b1);
		rdchk(`QED_OFF_COUNT, 32'h4);
		chk({31'h0, direction_up}, 32'h1, "direction");
		rdchk(`QED_OFF_STATE, 32'h1);
		chk(32'(vel_cnt), 32'h1, "velocity pulses");
		rdchk(`QED_OFF_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h0, "masked irq");
		$display("Test x4 up done");
		wr(`QED_OFF_STATUS, 32'h7);
		wr(`QED_OFF_CTRL, 32'h1);
		repeat (4) enc.step(1'b1);
		rdchk(`QED_OFF_COUNT, 32'h6);
		$display("Test x2 up done");
		wr(`QED_OFF_STATUS, 32'h7);
		wr(`QED_OFF_CTRL, 32'h3);
		enc.step(1'b0);
		rdchk(`QED_OFF_COUNT, 32'h5);
		chk({31'h0, direction_up}, 32'h0, "direction");
		rdchk(`QED_OFF_STATUS, 32'h4);
		$display("Test reversal done");
		wr(`QED_OFF_STATUS, 32'h7);
		wr(`QED_OFF_LIMIT, 32'h5);
		wr(`QED_OFF_MASK, 32'h2);
		enc.step(1'b1);
		rdchk(`QED_OFF_COUNT, 32'h0);
		rdchk(`QED_OFF_STATUS, 32'h6);
		chk({31'h0, irq}, 32'h1, "irq raised");
		wr(`QED_OFF_STATUS, 32'h2);
		rdchk(`QED_OFF_STATUS, 32'h4);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		enc.step(1'b0);
		rdchk(`QED_OFF_COUNT, 32'h5);
		$display("Test limit rollover done");
		wr(`QED_OFF_STATUS, 32'h7);
		wr(`QED_OFF_CTRL, 32'h7);
		enc.index_pulse();
		rdchk(`QED_OFF_COUNT, 32'h0);
		rdchk(`QED_OFF_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h1, "index irq");
		$display("Test index clear done");
		wr(`QED_OFF_CTRL, 32'hB);
		wr(`QED_OFF_LIMIT, 32'hFFFF);
		wr(`QED_OFF_COUNT, 32'h1234);
		rdchk(`QED_OFF_COUNT, 32'h1234);
		wr(`QED_OFF_COUNT, 32'h0);
		wr(`QED_OFF_SCALE, 32'h2);
		vel_cnt = 0;
		repeat (6) enc.step(1'b1);
		chk(32'(vel_cnt), 32'h2, "postscaled pulses");
		rdchk(`QED_OFF_COUNT, 32'h6);
		$display("Test postscaler done");
		wr(`QED_OFF_CTRL, 32'h0);
		repeat (4) enc.step(1'b1);
		rdchk(`QED_OFF_COUNT, 32'h6);
		chk(32'(vel_cnt), 32'h2, "no pulses when off");
		$display("Test disabled done");
		finish_test();
	end
endmodule // qed_top_tb_top
